// ---- dscp_prio_params.svh ----
// constants for the middle slice of the dscp priority table
`ifndef DSCP_PRIO_PARAMS_SVH
`define DSCP_PRIO_PARAMS_SVH
// =====================================================================
// register indices (byte address is four times the index)
`define IDX_MAP_14_17 10'h065
`define IDX_MAP_18_1B 10'h066
`define IDX_MAP_1C_1F 10'h067
`define IDX_MAP_20_23 10'h068
`define IDX_MAP_24_27 10'h069
`define IDX_MAP_28_2B 10'h06a
`define IDX_MAP_2C_2F 10'h06b
`define IDX_MAP_30_33 10'h06c
// =====================================================================
// table slice layout
`define MAP_REG_COUNT 8
`define MAP_RESET 8'h00
`define CODE_FIRST 6'h14
`define CODE_LAST 6'h33
`define CODE_MSB 7
`define CODE_LSB 2
`define FIELD_W 2
// =====================================================================
// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define ADDR_W 12
`endif

// ---- dscp_prio_pkg.sv ----
// types shared by the dscp priority table slice
package dscp_prio_pkg;
  typedef logic [1:0] prio_t;
  typedef logic [7:0] map_reg_t;
  typedef logic [5:0] code_t;
  // a write held until both address and data have arrived
  typedef struct packed {
    logic [9:0] idx;
    logic ok;
    logic [7:0] data;
    logic lane;
  } wr_req_t;
endpackage : dscp_prio_pkg

// ---- dscp_priority_lookup_mid.sv ----
// dscp priority table slice for codes 0x14..0x33 with axi4-lite access
//
// Implementation choice: the AXI4-Lite slave port.
`include "dscp_prio_params.svh"

module dscp_priority_lookup_mid
  import dscp_prio_pkg::*;
(
  input wire logic CORE_CLK_IN,
  input wire logic RESET_IN,
  input wire logic [7:0] TOS_IN,
  output logic [1:0] PRIO_OUT,
  output logic HIT_OUT,
  input wire logic [11:0] AWADDR_IN,
  input wire logic AWVALID_IN,
  output logic AWREADY_OUT,
  input wire logic [31:0] WDATA_IN,
  input wire logic [3:0] WSTRB_IN,
  input wire logic WVALID_IN,
  output logic WREADY_OUT,
  output logic [1:0] BRESP_OUT,
  output logic BVALID_OUT,
  input wire logic BREADY_IN,
  input wire logic [11:0] ARADDR_IN,
  input wire logic ARVALID_IN,
  output logic ARREADY_OUT,
  output logic [31:0] RDATA_OUT,
  output logic [1:0] RRESP_OUT,
  output logic RVALID_OUT,
  input wire logic RREADY_IN
);

  // ===================================================================
  // declarations
  // map storage and the flattened table slice
  map_reg_t map_r [`MAP_REG_COUNT];
  logic [63:0] flat;
  logic [63:0] sel;
  prio_t fld [64];
  // lookup path
  code_t code;
  prio_t prio_c;
  logic hit_c;
  prio_t prio_r, prio_nxt;
  logic hit_r, hit_nxt;
  // write channel state
  wr_req_t wr_r, wr_nxt;
  logic aw_have_r, aw_have_nxt;
  logic w_have_r, w_have_nxt;
  logic awready_r, awready_nxt;
  logic wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  // read channel state
  logic arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  // address decode helpers
  logic commit;
  logic [9:0] rd_idx;
  logic [9:0] rd_off;
  logic rd_ok;
  logic [9:0] wr_off;

  // ===================================================================
  // map registers, one per group of four codes
  // the one cycle in which a held write lands
  assign commit = aw_have_r & w_have_r & ~bvalid_r;
  assign wr_off = wr_r.idx - `IDX_MAP_14_17;
  // wr_off wraps for indices below the slice; wr_r.ok already
  // refuses those, so a wrapped offset never lands

  genvar gr;
  generate
    for (gr = 0; gr < `MAP_REG_COUNT; gr++)
    begin : g_map
      map_reg_t reg_nxt;
      // write lands when address and data are both held
      // a cleared byte strobe leaves the register untouched
      always_comb
      begin
        reg_nxt = map_r[gr];
        if (commit && wr_r.ok && wr_r.lane && wr_off == 10'(gr))
          reg_nxt = wr_r.data;
      end
      // reset value comes from the header, so every field reads 00
      always_ff @(posedge CORE_CLK_IN or posedge RESET_IN)
      begin
        if (RESET_IN)
          map_r[gr] <= `MAP_RESET;
        else
          map_r[gr] <= reg_nxt;
      end
      // register gr covers codes 0x14+4*gr .. 0x17+4*gr, low code at bit 0
      assign flat[gr*8 +: 8] = map_r[gr];
    end
  endgenerate

  // ===================================================================
  // full decode of the code into 64 selects
  // the two low bits of the tos byte never reach the decode
  assign code = TOS_IN[`CODE_MSB:`CODE_LSB];

  // one select per code value, 64 in all
  genvar gc;
  generate
    for (gc = 0; gc < 64; gc++)
    begin : g_dec
      assign sel[gc] = (code == 6'(gc));
      // selects outside this slice feed no field here: the
      // neighbouring slices own those codes
      if (gc >= `CODE_FIRST && gc <= `CODE_LAST)
      begin : g_in
        // field of code gc sits at twice its offset into the slice
        assign fld[gc] = {2{sel[gc]}} &
          flat[(gc - `CODE_FIRST) * `FIELD_W +: `FIELD_W];
      end
      else
      begin : g_out
        assign fld[gc] = 2'h0;
      end
    end
  endgenerate

  // or together the selected field against current contents
  // at most one select is high, so or-ing masked fields is safe
  always_comb
  begin
    prio_c = 2'h0;
    for (int i = 0; i < 64; i++)
      prio_c = prio_c | fld[i];
    hit_c = (code >= `CODE_FIRST) && (code <= `CODE_LAST);
    prio_nxt = prio_c;
    hit_nxt = hit_c;
  end

  // register the result so both lookup outputs come from flops;
  // a write landing at edge n shows from edge n+1
  always_ff @(posedge CORE_CLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      prio_r <= 2'h0;
      hit_r <= 1'b0;
    end
    else
    begin
      prio_r <= prio_nxt;
      hit_r <= hit_nxt;
    end
  end

  // ===================================================================
  // write channel: address and data accepted in either order
  always_comb
  begin
    // hold everything unless a channel moves
    wr_nxt = wr_r;
    aw_have_nxt = aw_have_r;
    w_have_nxt = w_have_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    // address side: range and alignment judged once, so the
    // response and the landing share one flag
    if (AWVALID_IN && awready_r)
    begin
      aw_have_nxt = 1'b1;
      wr_nxt.idx = AWADDR_IN[11:2];
      wr_nxt.ok = (AWADDR_IN[1:0] == 2'h0) &&
        (AWADDR_IN[11:2] >= `IDX_MAP_14_17) &&
        (AWADDR_IN[11:2] <= `IDX_MAP_30_33);
    end
    // data side: only the low byte lane holds a map register
    if (WVALID_IN && wready_r)
    begin
      w_have_nxt = 1'b1;
      wr_nxt.data = WDATA_IN[7:0];
      wr_nxt.lane = WSTRB_IN[0];
    end
    // land the write and raise the response; no new handshake starts
    // until the response is taken, so the set and the clear of
    // bvalid never fall in one cycle
    if (commit)
    begin
      aw_have_nxt = 1'b0;
      w_have_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = wr_r.ok ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (bvalid_r && BREADY_IN)
      bvalid_nxt = 1'b0;
    // readies follow the next state so a second request is not
    // taken while the first is pending
    awready_nxt = ~aw_have_nxt & ~bvalid_nxt;
    wready_nxt = ~w_have_nxt & ~bvalid_nxt;
  end

  // readies reset low so nothing is taken while reset is released
  always_ff @(posedge CORE_CLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      wr_r <= '0;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
    end
    else
    begin
      wr_r <= wr_nxt;
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
    end
  end

  // ===================================================================
  // read channel: answer one cycle after the address is taken
  // out-of-range and unaligned addresses are refused
  assign rd_idx = ARADDR_IN[11:2];
  assign rd_off = rd_idx - `IDX_MAP_14_17;
  assign rd_ok = (ARADDR_IN[1:0] == 2'h0) &&
    (rd_idx >= `IDX_MAP_14_17) && (rd_idx <= `IDX_MAP_30_33);

  always_comb
  begin
    // hold the answer until it is taken
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    // a refused read answers slverr with zero data; a good one is
    // picked from the live register, so it sees a write just landed
    if (ARVALID_IN && arready_r)
    begin
      rvalid_nxt = 1'b1;
      rdata_nxt = 32'h0;
      rresp_nxt = `RESP_SLVERR;
      if (rd_ok)
      begin
        rdata_nxt = {24'h0, map_r[rd_off[2:0]]};
        rresp_nxt = `RESP_OKAY;
      end
    end
    else if (rvalid_r && RREADY_IN)
      rvalid_nxt = 1'b0;
    // one read at a time: the address side closes while data stands
    arready_nxt = ~rvalid_nxt;
  end

  // register the read channel; arready resets low
  always_ff @(posedge CORE_CLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= `RESP_OKAY;
      arready_r <= 1'b0;
    end
    else
    begin
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      arready_r <= arready_nxt;
    end
  end

  // ===================================================================
  // outputs, all from flip-flops
  // the bus and lookup ports never see a combinational path
  assign PRIO_OUT = prio_r;
  assign HIT_OUT = hit_r;
  assign AWREADY_OUT = awready_r;
  assign WREADY_OUT = wready_r;
  assign BVALID_OUT = bvalid_r;
  assign BRESP_OUT = bresp_r;
  assign ARREADY_OUT = arready_r;
  assign RVALID_OUT = rvalid_r;
  assign RDATA_OUT = rdata_r;
  assign RRESP_OUT = rresp_r;

endmodule : dscp_priority_lookup_mid

// ---- dscp_priority_lookup_mid_asserts.sv ----
// checker for the dscp priority slice
module dscp_lookup_chk (
  input wire logic CORE_CLK_IN,
  input wire logic RESET_IN,
  input wire logic [7:0] TOS_IN,
  input wire logic [1:0] PRIO_OUT,
  input wire logic HIT_OUT,
  input wire logic AWVALID_IN,
  input wire logic AWREADY_OUT,
  input wire logic WVALID_IN,
  input wire logic WREADY_OUT,
  input wire logic [1:0] BRESP_OUT,
  input wire logic BVALID_OUT,
  input wire logic BREADY_IN,
  input wire logic ARVALID_IN,
  input wire logic ARREADY_OUT,
  input wire logic [31:0] RDATA_OUT,
  input wire logic RVALID_OUT,
  input wire logic RREADY_IN
);
  // ====
  // lookup and bus properties
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (RESET_IN);
  property p_hit;
    TOS_IN[7:2] inside {[6'h14:6'h33]} |=> HIT_OUT;
  endproperty
  property p_miss;
    !(TOS_IN[7:2] inside {[6'h14:6'h33]}) |=> !HIT_OUT && PRIO_OUT == 2'h0;
  endproperty
  property p_b;
    AWVALID_IN && AWREADY_OUT && WVALID_IN && WREADY_OUT |-> ##2 BVALID_OUT;
  endproperty
  property p_bh;
    BVALID_OUT && !BREADY_IN |=> BVALID_OUT && $stable(BRESP_OUT);
  endproperty
  property p_bend;
    BVALID_OUT && BREADY_IN |=> !BVALID_OUT ##1 AWREADY_OUT && WREADY_OUT;
  endproperty
  property p_r;
    ARVALID_IN && ARREADY_OUT |=> RVALID_OUT;
  endproperty
  property p_rh;
    RVALID_OUT && !RREADY_IN |=> RVALID_OUT && $stable(RDATA_OUT);
  endproperty
  property p_rz;
    RVALID_OUT |-> RDATA_OUT[31:8] == 24'h0 && !ARREADY_OUT;
  endproperty
  a_hit: assert property (p_hit) else $error("code not hit");
  a_miss: assert property (p_miss) else $error("stray hit");
  a_b: assert property (p_b) else $error("no write answer");
  a_bh: assert property (p_bh) else $error("write answer moved");
  a_bend: assert property (p_bend) else $error("write not closed");
  a_r: assert property (p_r) else $error("no read answer");
  a_rh: assert property (p_rh) else $error("read data moved");
  a_rz: assert property (p_rz) else $error("bad read word");
  c_wr: cover property (BVALID_OUT && BREADY_IN);
  c_rd: cover property (RVALID_OUT && RREADY_IN);
  c_hi: cover property (HIT_OUT && PRIO_OUT == 2'h3);
endmodule : dscp_lookup_chk
bind dscp_priority_lookup_mid dscp_lookup_chk dscp_lookup_chk_i (.*);

// ---- dscp_priority_lookup_mid_test.sv ----
// testbench for the dscp priority slice
`include "dscp_prio_params.svh"
module dscp_priority_lookup_mid_test
  import dscp_prio_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic CORE_CLK_IN = 0, RESET_IN = 1;
  logic [7:0] TOS_IN = 0;
  logic [11:0] AWADDR_IN = 0, ARADDR_IN = 0;
  logic [31:0] WDATA_IN = 0, RDATA_OUT;
  logic [3:0] WSTRB_IN = 0;
  logic AWVALID_IN = 0, WVALID_IN = 0, BREADY_IN = 0;
  logic ARVALID_IN = 0, RREADY_IN = 0, HIT_OUT, RVALID_OUT;
  logic AWREADY_OUT, WREADY_OUT, BVALID_OUT, ARREADY_OUT;
  logic [1:0] PRIO_OUT, BRESP_OUT, RRESP_OUT, r;
  logic [31:0] d;
  int error_cnt = 0, total_checks = 0;
  map_reg_t v [8];
  dscp_priority_lookup_mid dscp_priority_lookup_mid_i (.*);
  // 40 MHz clock
  always #12.5 CORE_CLK_IN = ~CORE_CLK_IN;
  // ====
  // shared tasks
  task report_and_stop;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  task chk(input string n, input logic [31:0] s, e);
    total_checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task tick(inout int n);
    @(posedge CORE_CLK_IN);
    if (++n > 40)
    begin
      error_cnt++;
      report_and_stop();
    end
  endtask : tick
  function logic [11:0] ad(int k);
    return {10'(`IDX_MAP_14_17 + k), 2'h0};
  endfunction : ad
  task wr(input logic [11:0] a, input map_reg_t w, input logic s);
    int n;
    n = 0;
    @(posedge CORE_CLK_IN);
    AWADDR_IN <= a;
    WDATA_IN <= {24'h0, w};
    WSTRB_IN <= {3'h0, s};
    AWVALID_IN <= 1;
    WVALID_IN <= 1;
    BREADY_IN <= 1;
    do
    begin
      tick(n);
      if (AWREADY_OUT) AWVALID_IN <= 0;
      if (WREADY_OUT) WVALID_IN <= 0;
    end
    while (!BVALID_OUT);
    r = BRESP_OUT;
    BREADY_IN <= 0;
  endtask : wr
  task rd(input logic [11:0] a);
    int n;
    n = 0;
    @(posedge CORE_CLK_IN);
    ARADDR_IN <= a;
    ARVALID_IN <= 1;
    RREADY_IN <= 1;
    do
    begin
      tick(n);
      if (ARREADY_OUT) ARVALID_IN <= 0;
    end
    while (!RVALID_OUT);
    d = RDATA_OUT;
    r = RRESP_OUT;
    RREADY_IN <= 0;
  endtask : rd
  task look(input logic [7:0] t, input prio_t p, input logic h);
    @(posedge CORE_CLK_IN);
    TOS_IN <= t;
    @(posedge CORE_CLK_IN);
    #1;
    chk("prio", PRIO_OUT, p);
    chk("hit", HIT_OUT, h);
  endtask : look
  // ====
  // scenarios
  task t_reset;
    for (int k = 0; k < 8; k++)
    begin
      rd(ad(k));
      chk("reset", d, 32'h0);
    end
    look(8'h80, 2'h0, 1);
    $display("reset test done");
  endtask : t_reset
  task t_map;
    for (int k = 0; k < 8; k++)
    begin
      v[k] = 8'(k * 8'h39 + 8'h1e);
      wr(ad(k), v[k], 1);
      chk("wresp", r, `RESP_OKAY);
      rd(ad(k));
      chk("readback", d, {24'h0, v[k]});
      chk("rresp", r, `RESP_OKAY);
    end
    for (int c = 'h14; c <= 'h33; c++)
      look({6'(c), 2'(c)}, v[(c - 20) / 4][2 * ((c - 20) % 4) +: 2], 1);
    look(8'h4f, 2'h0, 0);
    look(8'hd3, 2'h0, 0);
    $display("map test done");
  endtask : t_map
  task t_err;
    wr(12'h1b4, 8'hff, 1);
    chk("unmapped", r, `RESP_SLVERR);
    rd(12'h199);
    chk("unaligned resp", r, `RESP_SLVERR);
    chk("unaligned data", d, 32'h0);
    wr(ad(0), 8'h00, 0);
    chk("no strobe resp", r, `RESP_OKAY);
    rd(ad(0));
    chk("no strobe", d, {24'h0, v[0]});
    wr(ad(7), 8'h03, 1);
    chk("wresp 6c", r, `RESP_OKAY);
    look(8'hc1, 2'h3, 1);
    $display("error test done");
  endtask : t_err
  initial
  begin
    repeat (12) @(posedge CORE_CLK_IN);
    RESET_IN <= 0;
    t_reset();
    t_map();
    t_err();
    report_and_stop();
  end
endmodule : dscp_priority_lookup_mid_test
